// ==== rtl/pafm_consts.svh ====
// constants for the port alternate function mux
// Overview of operation
// R1: reset clears both the motor port mode and the A/D pin config registers.
// R2: both registers accept single-bit writes as well as whole-byte writes.
// R3: a disabled motor group leaves all four of its pins as plain port pins.
// R4: an enabled group in bridge mode 0 drives its four outputs full-bridge.
// R5: an enabled group in bridge mode 1 lets its direction pair pick PWM or port.
// R6: full-bridge pairs 00,01,10,11 route PWM,0,PWM,0 / PWM,0,0,PWM / 0,PWM,0,PWM / 0,PWM,PWM,0.
// R7: half-bridge pairs route the same PWM places, with port instead of 0.
// R8: software clears port data and direction of non-PWM pins in full-bridge.
// R9: the A/D field makes the lowest N analog pins digital, N up to 8.
// R10: software sets each conversion channel pin to input direction.
// R11: software never selects a digital pin as an A/D channel.
// R12: a write to the A/D config register stalls the CPU one wait cycle.
// R13: input switch bits move timer and UART signals to alternate pins.
// R14: software programs segment, motor, switch, direction and latch per pin.
// R15: a set segment bit forces segment output; clear gives port and timer.
// R16: direction bit 0 turns the output buffer on, 1 turns it off.
`ifndef PAFM_CONSTS_SVH
`define PAFM_CONSTS_SVH
`define PAFM_ADDR_ANALOG_DIGITAL_PIN_CONFIG     16'hff22
`define PAFM_ADDR_MOTOR_PORT_MODE_CONTROL     16'hff3d
`define PAFM_RST_ANALOG_DIGITAL_PIN_CONFIG      8'h00
`define PAFM_RST_MOTOR_PORT_MODE_CONTROL      8'h00
`define PAFM_ANALOG_DIGITAL_PIN_CONFIG_MAX      4'h8
`define PAFM_MOTOR_PORT_MODE_CONTROL_MOD_LSB  4
`define PAFM_WAIT_CYCLES   1
`endif

// ==== rtl/pafm_pkg.sv ====
// types for the port alternate function mux
package pafm_pkg;
  // per-pin routing of a motor coil output
  typedef enum logic [2:0] {
    PAFM_ROUTE_PORT = 3'b001,
    PAFM_ROUTE_PWM  = 3'b010,
    PAFM_ROUTE_ZERO = 3'b100
  } pafm_route_e;
  // cpu register access
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        bit_op;
    logic [2:0]  bit_idx;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pafm_req_s;
endpackage : pafm_pkg

// ==== rtl/pafm_mux.sv ====
// port alternate function mux: motor port mode, A/D config, pin routing
`include "pafm_consts.svh"
module pafm_mux #(
  parameter int GROUPS  = 4,
  parameter int ANALOG  = 8,
  parameter int SEGPINS = 8
) (
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RESETN,
  // cpu register access
  input  pafm_pkg::pafm_req_s        REQ,
  output logic [7:0]                 RDATA,
  output logic                       WAIT,
  // motor compare control direction bits and pwm, two bits per group
  input  wire logic [2*GROUPS-1:0]   DIR_BITS,
  input  wire logic [GROUPS-1:0]     PWM_SIN,
  input  wire logic [GROUPS-1:0]     PWM_COS,
  // port latches and directions of the motor pins
  input  wire logic [4*GROUPS-1:0]   MOTOR_LATCH,
  input  wire logic [4*GROUPS-1:0]   MOTOR_DIR,
  // motor pin drive
  output logic [4*GROUPS-1:0]        MOTOR_OUT,
  output logic [4*GROUPS-1:0]        MOTOR_OE,
  // analog pins: 1 = digital i/o
  output logic [ANALOG-1:0]          ANALOG_DIGITAL,
  // segment / timer shared pins
  input  wire logic [SEGPINS-1:0]    SEG_ENABLE,
  input  wire logic [SEGPINS-1:0]    SEG_DATA,
  input  wire logic [SEGPINS-1:0]    PORT_LATCH,
  input  wire logic [SEGPINS-1:0]    PORT_DIR,
  input  wire logic [SEGPINS-1:0]    TIMER_OUT,
  input  wire logic [SEGPINS-1:0]    TIMER_SEL,
  output logic [SEGPINS-1:0]         SEG_PIN_OUT,
  output logic [SEGPINS-1:0]         SEG_PIN_OE,
  // input switch: 1 moves timer/uart to the alternate pin
  input  wire logic                  SWITCH_BIT,
  input  wire logic                  TIMER_SIG,
  input  wire logic                  UART_TX,
  output logic [1:0]                 TIMER_PIN_OUT,
  output logic [1:0]                 UART_PIN_OUT
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [7:0] motor_port_mode_control_q, motor_port_mode_control_d;
  logic [3:0] analog_digital_pin_config_q, analog_digital_pin_config_d;
  logic       wait_q, wait_d;
  logic       hit_motor_port_mode_control, hit_analog_digital_pin_config;

  assign hit_motor_port_mode_control = REQ.addr == `PAFM_ADDR_MOTOR_PORT_MODE_CONTROL;
  assign hit_analog_digital_pin_config = REQ.addr == `PAFM_ADDR_ANALOG_DIGITAL_PIN_CONFIG;

  // a bit write touches one bit only; the rest of the byte is kept
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input pafm_pkg::pafm_req_s r);
    logic [7:0] res;
    res = old;
    if (r.bit_op) begin
      res[r.bit_idx] = r.wdata[0];
    end else begin
      res = r.wdata;
    end
    return res;
  endfunction : merge

  always_comb begin
    logic [7:0] a8;
    a8 = merge({4'h0, analog_digital_pin_config_q}, REQ);
    motor_port_mode_control_d = motor_port_mode_control_q;
    analog_digital_pin_config_d = analog_digital_pin_config_q;
    wait_d = 1'b0;
    if (REQ.wr && hit_motor_port_mode_control) begin
      motor_port_mode_control_d = merge(motor_port_mode_control_q, REQ); // R2
    end
    if (REQ.wr && hit_analog_digital_pin_config) begin
      analog_digital_pin_config_d = a8[3:0]; // R2
      wait_d = 1'b1; // R12
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      motor_port_mode_control_q <= `PAFM_RST_MOTOR_PORT_MODE_CONTROL; // R1
      analog_digital_pin_config_q <= 4'(`PAFM_RST_ANALOG_DIGITAL_PIN_CONFIG); // R1
      wait_q <= 1'b0;
    end else begin
      motor_port_mode_control_q <= motor_port_mode_control_d;
      analog_digital_pin_config_q <= analog_digital_pin_config_d;
      wait_q <= wait_d;
    end
  end

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  logic [7:0] rdata_d, rdata_q;
  always_comb begin
    rdata_d = 8'h00;
    if (REQ.rd && hit_motor_port_mode_control) begin
      rdata_d = motor_port_mode_control_q;
    end else if (REQ.rd && hit_analog_digital_pin_config) begin
      rdata_d = {4'h0, analog_digital_pin_config_q};
    end
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign RDATA = rdata_q;
  assign WAIT  = wait_q;

  // ------------------------------------------------------------------
  // motor groups
  // ------------------------------------------------------------------
  logic [4*GROUPS-1:0] mout_d, moe_d, mout_q, moe_q;
  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : g_grp
      pafm_pkg::pafm_route_e rt [4];
      logic [3:0] pwm;
      logic [3:0] gout, goe;
      logic       en, md;
      logic [1:0] dir;
      assign en  = motor_port_mode_control_q[g];
      assign md  = motor_port_mode_control_q[`PAFM_MOTOR_PORT_MODE_CONTROL_MOD_LSB+g];
      assign dir = DIR_BITS[2*g+:2];
      assign pwm = {PWM_COS[g], PWM_COS[g], PWM_SIN[g], PWM_SIN[g]};
      // each group owns its own slice, so no two processes share a target
      assign mout_d[4*g+:4] = gout;
      assign moe_d[4*g+:4]  = goe;
      always_comb begin
        logic [3:0] sel;
        sel = 4'b0000;
        // pwm places in order sin+, sin-, cos+, cos- (bit 0 = sin+)
        unique case (dir)
          2'b00: sel = 4'b0101; // R6 R7
          2'b01: sel = 4'b1001; // R6 R7
          2'b10: sel = 4'b1010; // R6 R7
          2'b11: sel = 4'b0110; // R6 R7
        endcase
        for (int k = 0; k < 4; k++) begin
          if (!en) begin
            rt[k] = pafm_pkg::PAFM_ROUTE_PORT; // R3
          end else if (sel[k]) begin
            rt[k] = pafm_pkg::PAFM_ROUTE_PWM; // R4 R5
          end else if (md) begin
            rt[k] = pafm_pkg::PAFM_ROUTE_PORT; // R5 R7
          end else begin
            rt[k] = pafm_pkg::PAFM_ROUTE_ZERO; // R4 R6
          end
          unique case (rt[k])
            pafm_pkg::PAFM_ROUTE_PWM: begin
              gout[k] = pwm[k];
              goe[k]  = 1'b1;
            end
            pafm_pkg::PAFM_ROUTE_ZERO: begin
              gout[k] = 1'b0;
              goe[k]  = 1'b1;
            end
            default: begin
              gout[k] = MOTOR_LATCH[4*g+k];
              goe[k]  = ~MOTOR_DIR[4*g+k]; // R16
            end
          endcase
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // analog/digital split, segment pins, input switch
  // ------------------------------------------------------------------
  logic [ANALOG-1:0]  adig_d, adig_q;
  logic [SEGPINS-1:0] sout_d, soe_d, sout_q, soe_q;
  logic [1:0]         tpin_d, upin_d, tpin_q, upin_q;

  always_comb begin
    for (int i = 0; i < ANALOG; i++) begin
      // prohibited codes above 8 are treated as all digital
      adig_d[i] = (i < int'(analog_digital_pin_config_q)); // R9
    end
    for (int i = 0; i < SEGPINS; i++) begin
      if (SEG_ENABLE[i]) begin
        sout_d[i] = SEG_DATA[i]; // R15
        soe_d[i]  = 1'b1; // R15
      end else begin
        sout_d[i] = TIMER_SEL[i] ? TIMER_OUT[i] : PORT_LATCH[i]; // R15
        soe_d[i]  = ~PORT_DIR[i]; // R16
      end
    end
    // unselected pin idles high for uart, low for timer
    tpin_d = SWITCH_BIT ? {TIMER_SIG, 1'b0} : {1'b0, TIMER_SIG}; // R13
    upin_d = SWITCH_BIT ? {UART_TX, 1'b1} : {1'b1, UART_TX}; // R13
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      mout_q <= '0;
      moe_q  <= '0;
      adig_q <= '0;
      sout_q <= '0;
      soe_q  <= '0;
      tpin_q <= 2'h0;
      upin_q <= 2'h3;
    end else begin
      mout_q <= mout_d;
      moe_q  <= moe_d;
      adig_q <= adig_d;
      sout_q <= sout_d;
      soe_q  <= soe_d;
      tpin_q <= tpin_d;
      upin_q <= upin_d;
    end
  end

  assign MOTOR_OUT      = mout_q;
  assign MOTOR_OE       = moe_q;
  assign ANALOG_DIGITAL = adig_q;
  assign SEG_PIN_OUT    = sout_q;
  assign SEG_PIN_OE     = soe_q;
  assign TIMER_PIN_OUT  = tpin_q;
  assign UART_PIN_OUT   = upin_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_analog_digital_pin_config_wait_pulse: assert property ( // R12
    (REQ.wr && hit_analog_digital_pin_config) |=> WAIT) else $error("no wait after analog_digital_pin_config write");
  a_no_spurious_wait: assert property ( // R12
    !(REQ.wr && hit_analog_digital_pin_config) |=> !WAIT) else $error("spurious wait");
  a_group_off_port: assert property ( // R3
    !motor_port_mode_control_q[0] && !$past(motor_port_mode_control_q[0]) |=> MOTOR_OE[3:0] == $past(~MOTOR_DIR[3:0]))
    else $error("disabled group not port");
  a_full_zero: assert property ( // R6
    motor_port_mode_control_q[0] && !motor_port_mode_control_q[4] && DIR_BITS[1:0] == 2'b00
    |=> MOTOR_OUT[1] == 1'b0 && MOTOR_OUT[3] == 1'b0 && MOTOR_OE[1])
    else $error("full bridge zero wrong");
  a_half_port: assert property ( // R7
    motor_port_mode_control_q[0] && motor_port_mode_control_q[4] && DIR_BITS[1:0] == 2'b11
    |=> MOTOR_OUT[0] == $past(MOTOR_LATCH[0])) else $error("half port wrong");
  a_adig_count: assert property ( // R9
    analog_digital_pin_config_q == 4'h3 && $stable(analog_digital_pin_config_q) |=> ANALOG_DIGITAL == 8'h07)
    else $error("digital split wrong");
  a_seg_force: assert property ( // R15
    SEG_ENABLE[0] |=> SEG_PIN_OE[0] && SEG_PIN_OUT[0] == $past(SEG_DATA[0]))
    else $error("segment not forced");
  a_bit_write: assert property ( // R2
    REQ.wr && hit_motor_port_mode_control && REQ.bit_op && REQ.bit_idx == 3'd7
    |=> motor_port_mode_control_q[6:0] == $past(motor_port_mode_control_q[6:0])) else $error("bit write spilled");
  a_switch_move: assert property ( // R13
    SWITCH_BIT |=> UART_PIN_OUT[1] == $past(UART_TX))
    else $error("uart not moved");

  // one write to the config register stalls the cpu for exactly one cycle
  sequence s_analog_digital_pin_config_write;
    REQ.wr && hit_analog_digital_pin_config;
  endsequence

  sequence s_no_analog_digital_pin_config_write;
    !(REQ.wr && hit_analog_digital_pin_config);
  endsequence

  a_wait_one_cycle: assert property ( // R12
    s_analog_digital_pin_config_write ##1 s_no_analog_digital_pin_config_write |-> WAIT ##1 !WAIT)
    else $error("wait not a single cycle");

  a_reset_clear: assert property ( // R1
    $rose(RESETN) |-> motor_port_mode_control_q == `PAFM_RST_MOTOR_PORT_MODE_CONTROL && analog_digital_pin_config_q == 4'h0)
    else $error("registers not cleared by reset");

  a_full_drive_oe: assert property ( // R4
    motor_port_mode_control_q[0] && !motor_port_mode_control_q[4] |=> MOTOR_OE[3:0] == 4'hf)
    else $error("full bridge pin not driven");

  a_half_pwm_route: assert property ( // R5
    motor_port_mode_control_q[0] && motor_port_mode_control_q[4] && DIR_BITS[1:0] == 2'b00
    |=> MOTOR_OUT[0] == $past(PWM_SIN[0]) && MOTOR_OE[0])
    else $error("half bridge pwm not routed");

  a_last_group_port: assert property ( // R3
    !motor_port_mode_control_q[GROUPS-1]
    |=> MOTOR_OE[4*GROUPS-1-:4] == $past(~MOTOR_DIR[4*GROUPS-1-:4]))
    else $error("last group not port");

  a_adig_over_range: assert property ( // R9
    analog_digital_pin_config_q > `PAFM_ANALOG_DIGITAL_PIN_CONFIG_MAX |=> &ANALOG_DIGITAL)
    else $error("prohibited code not all digital");

  a_seg_port_oe: assert property ( // R16
    !SEG_ENABLE[0] |=> SEG_PIN_OE[0] == $past(~PORT_DIR[0]))
    else $error("port direction not obeyed");

  a_timer_home_pin: assert property ( // R13
    !SWITCH_BIT |=> TIMER_PIN_OUT == {1'b0, $past(TIMER_SIG)})
    else $error("timer not on primary pin");

endmodule : pafm_mux

// ==== verif/pafm_cmp_model.sv ====
// compare control model: direction pairs and pwm levels toward the mux
module pafm_cmp_model #(
  parameter int GROUPS = 4
) (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                RESETN,
  // direction pairs asked for by the bench
  input  wire logic [2*GROUPS-1:0] DIR_SET,
  // toward the mux
  output logic      [2*GROUPS-1:0] DIR_BITS,
  output logic      [GROUPS-1:0]   PWM_SIN,
  output logic      [GROUPS-1:0]   PWM_COS
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2*GROUPS-1:0] dir_q;
  // direction changes land on an edge, as the compare block's register does
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      dir_q <= '0;
    end else begin
      dir_q <= DIR_SET;
    end
  end
  assign DIR_BITS = dir_q;
  // pwm held at its on level so a routed pin differs from a forced zero
  assign PWM_SIN = {GROUPS{RESETN}};
  assign PWM_COS = {GROUPS{RESETN}};
endmodule : pafm_cmp_model

// ==== verif/tb.sv ====
// self-checking bench for the port alternate function mux
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pafm_pkg::pafm_req_s req = '0;
  logic [7:0]  rdata, ana, dset = 8'h00, dirb;
  logic [7:0]  sen = '0, sdat = '0, plat = '0, pdir = '0, tout = '0;
  logic [7:0]  tsel = '0, sout, soe;
  logic [3:0]  psin, pcos;
  logic [15:0] mlat = '0, mdir = '0, mout, moe;
  logic        wt, sw = 1'b0, tsig = 1'b0, utx = 1'b0;
  logic [1:0]  tpin, upin;
  int          miscompares = 0;
  int          samples_checked = 0;
  always #50 clk = ~clk;
  pafm_mux i_pafm_mux (.CLK(clk), .RESETN(rst_n), .REQ(req), .RDATA(rdata),
    .WAIT(wt), .DIR_BITS(dirb), .PWM_SIN(psin), .PWM_COS(pcos),
    .MOTOR_LATCH(mlat), .MOTOR_DIR(mdir), .MOTOR_OUT(mout), .MOTOR_OE(moe),
    .ANALOG_DIGITAL(ana), .SEG_ENABLE(sen), .SEG_DATA(sdat),
    .PORT_LATCH(plat), .PORT_DIR(pdir), .TIMER_OUT(tout), .TIMER_SEL(tsel),
    .SEG_PIN_OUT(sout), .SEG_PIN_OE(soe), .SWITCH_BIT(sw), .TIMER_SIG(tsig),
    .UART_TX(utx), .TIMER_PIN_OUT(tpin), .UART_PIN_OUT(upin));
  pafm_cmp_model i_pafm_cmp_model (.CLK(clk), .RESETN(rst_n),
    .DIR_SET(dset), .DIR_BITS(dirb), .PWM_SIN(psin), .PWM_COS(pcos));
  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // request stands one cycle; taken at the second edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic b, input logic [2:0] i);
    pafm_pkg::pafm_req_s r;
    r = '0;
    r.wr = 1'b1;
    r.bit_op = b;
    r.bit_idx = i;
    r.addr = a;
    r.wdata = d;
    @(posedge clk) req <= r;
    @(posedge clk) req <= '0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    pafm_pkg::pafm_req_s r;
    r = '0;
    r.rd = 1'b1;
    r.addr = a;
    @(posedge clk) req <= r;
    @(posedge clk) req <= '0;
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask : rd
  task automatic wrap_up;
    $display("checked %0d, wrong %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [7:0]  motor_port_mode_control;
    logic [3:0]  msk;
    logic [15:0] eo, ee;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(16'hff3d, 8'h00);
    rd(16'hff22, 8'h00);
    rd(16'hff00, 8'h00);
    for (int n = 0; n <= 8; n++) begin
      wr(16'hff22, 8'(n), 1'b0, 3'h0);
      #1 chk({15'h0000, wt}, 16'h0001);
      @(posedge clk);
      #1 chk({8'h00, ana}, 16'((1 << n) - 1));
      chk({15'h0000, wt}, 16'h0000);
      // the bench converts only on pin n, which must still be analog
      if (n < 8) begin
        chk({15'h0000, ana[n]}, 16'h0000);
      end
      rd(16'hff22, 8'(n));
    end
    wr(16'hff22, 8'hf3, 1'b0, 3'h0);
    rd(16'hff22, 8'h03);
    wr(16'hff22, 8'h01, 1'b1, 3'h3);
    rd(16'hff22, 8'h0b);
    chk({8'h00, ana}, 16'h00ff);
    // port with mode bits set, then full bridge, then half bridge
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 4; p++) begin
        motor_port_mode_control = (m == 0) ? 8'hf0 : (m == 1) ? 8'h0f : 8'hff;
        @(posedge clk);
        mlat <= (m == 1) ? 16'h0000 : 16'ha5a5;
        mdir <= (m == 1) ? 16'h0000 : 16'h0ff0;
        dset <= {4{2'(p)}};
        wr(16'hff3d, motor_port_mode_control, 1'b0, 3'h0);
        msk = (p == 0) ? 4'h5 : (p == 1) ? 4'h9 : (p == 2) ? 4'ha : 4'h6;
        for (int k = 0; k < 16; k++) begin
          if (m == 0 || (m == 2 && !msk[k % 4])) begin
            eo[k] = mlat[k];
            ee[k] = ~mdir[k];
          end else begin
            eo[k] = msk[k % 4];
            ee[k] = 1'b1;
          end
        end
        repeat (3) @(posedge clk);
        #1 chk(mout, eo);
        chk(moe, ee);
      end
    end
    wr(16'hff3d, 8'h00, 1'b1, 3'h7);
    rd(16'hff3d, 8'h7f);
    @(posedge clk);
    sen <= 8'h0f;
    sdat <= 8'h05;
    plat <= 8'h30;
    pdir <= 8'h50;
    tout <= 8'hc0;
    tsel <= 8'h80;
    tsig <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({8'h00, sout}, 16'h00b5);
    chk({8'h00, soe}, 16'h00af);
    chk({12'h000, tpin, upin}, 16'h0006);
    @(posedge clk);
    sw <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({12'h000, tpin, upin}, 16'h0009);
    wrap_up();
  end
endmodule : tb
